// file: ldp_pkg.sv
// ldp_pkg: shared constants of the led dimming pwm control link
// assumes pclk at 100 MHz and a link clock made by dividing pclk
package ldp_pkg;
   // clocking of the link
   localparam longint PCLK_PERIOD_NS = 10;
   localparam longint LINK_DIV       = 4;
   localparam longint LINK_PERIOD_NS = PCLK_PERIOD_NS * LINK_DIV;
   // enable qualification and shutdown timing
   localparam longint WAKE_MIN_NS    = 40000;
   localparam longint OFF_MAX_NS     = 28000000;
   localparam int     WAKE_CYC       = int'((WAKE_MIN_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
   localparam int     OFF_CYC_DFLT   = int'(OFF_MAX_NS / LINK_PERIOD_NS);
   localparam int     CNT_W          = 20;
   // device register map (byte addresses on the link)
   localparam logic [7:0] ADDR_LVL   = 8'h00;
   localparam logic [7:0] ADDR_MODE  = 8'h01;
   localparam logic [7:0] ADDR_DCL   = 8'h07;
   localparam logic [7:0] LVL_RST    = 8'hFF;
   localparam logic [7:0] DCL_RST    = 8'hFF;
   // dimming mode codes
   localparam logic [7:0] MODE_RATIO = 8'h01;
   localparam logic [7:0] MODE_EXT   = 8'h03;
   localparam logic [7:0] MODE_INT   = 8'h05;
   localparam logic [7:0] MODE_DC    = 8'h07;
   localparam logic [7:0] MODE_RST   = MODE_RATIO;
   // internal pwm: 256 duty steps over a 255 slot period
   localparam logic [7:0] PWM_LAST   = 8'hFE;
   // filter node level in 10 mV units
   localparam logic [7:0] FN_LO      = 8'h15;
   localparam logic [7:0] FN_HI      = 8'h79;
   localparam int         FN_SPAN    = 100;
   localparam int         EXT_FILT_SH = 6;
   // host apb register map
   localparam logic [7:0] H_DEV_ADDR = 8'h00;
   localparam logic [7:0] H_DEV_DATA = 8'h04;
   localparam logic [7:0] H_CMD      = 8'h08;
   localparam logic [7:0] H_RDATA    = 8'h0C;
   localparam logic [7:0] H_PWM_PER  = 8'h10;
   localparam logic [7:0] H_PWM_HIGH = 8'h14;
   localparam logic [7:0] H_STATUS   = 8'h18;
   localparam int         CMD_WR_BIT = 0;
   localparam int         CMD_RD_BIT = 1;
   localparam logic [15:0] PWM_PER_RST  = 16'h1000;
   localparam logic [15:0] PWM_HIGH_RST = 16'h0800;
endpackage : ldp_pkg

// file: ldp_link_if.sv
// ldp_link_if: wires between the dimming device and its host
// assumes the host drives link_clk and changes requests on its falling edge
`timescale 1ns/100ps
interface ldp_link_if;
   logic       link_clk;
   logic       enable_pwm_input;
   logic       reg_wr;
   logic       reg_rd;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic       reg_rack;
   logic       awake;

   modport dev  (input link_clk, enable_pwm_input, reg_wr, reg_rd, reg_addr, reg_wdata,
                 output reg_rdata, reg_rack, awake);
   modport host (output link_clk, enable_pwm_input, reg_wr, reg_rd, reg_addr, reg_wdata,
                 input reg_rdata, reg_rack, awake);
endinterface : ldp_link_if

// file: ldp_device.sv
// ldp_device: dimming control of a six channel led driver, on the link clock
// assumes the host holds each register request for one full link period
// Operation
// (RULE1) first input pulse of 40us wakes device
// (RULE2) no pulse beyond 28ms enters shutdown
// (RULE3) dc level takes 0..255, resets to 255
// (RULE4) new dc level applies live while running
// (RULE5) dc level zero disconnects every channel
// (RULE6) one pwm gate drives all six channels
// (RULE7) ratiometric mode is selected after reset
// (RULE8) internal mode: 256 steps, duty brightness/255
// (RULE9) brightness register at 0x00, resets 0xFF
// (RULE10) brightness zero disconnects every channel
// (RULE11) host writes 0x05 for internal mode
// (RULE12) host writes 0x03 for external mode
// (RULE13) external duty 10..99.5 percent, 20kHz
// (RULE14) host writes 0x01 plus external pwm
// (RULE15) ratiometric duty is brightness times external duty
// (RULE16) dc mode scales by filter node voltage
// (RULE17) external mode follows input frequency
// (RULE18) free running counter compared against duty
`timescale 1ns/100ps
module ldp_device #(
   parameter int OFF_CYC = ldp_pkg::OFF_CYC_DFLT,
   parameter int PWM_DIV = 1
) (
   // link to the host
   ldp_link_if.dev          link,
   // reset
   input  wire logic        presetn,
   // filter node level, 10 mV units
   input  wire logic [7:0]  pwm_filter_node,
   // led channel drive
   output logic      [5:0]  led_gate,
   output logic      [7:0]  dc_level
);
   import ldp_pkg::*;

   typedef enum logic [1:0] {
      ST_SLEEP = 2'b00,
      ST_QUAL  = 2'b01,
      ST_AWAKE = 2'b11
   } ldp_wake_e;

   function automatic logic [7:0] ldp_frac(input logic [7:0] a, input logic [7:0] b);
      logic [15:0] p;
      p = 16'(a) * 16'(b) + 16'h007F;
      return 8'(p / 16'h00FF);
   endfunction : ldp_frac

   ////////////////////////////////////////////////////////////////////////////
   // reset release and pin synchronisers
   logic [1:0]       rst_s_q;
   logic             rst_n;
   logic             pin_s1_q;
   logic             pin_s2_q;
   logic [7:0]       fn_s1_q;
   logic [7:0]       fn_s2_q;

   always_ff @(posedge link.link_clk or negedge presetn) begin
      if (!presetn) begin
         rst_s_q <= 2'b00;
      end else begin
         rst_s_q <= {rst_s_q[0], 1'b1};
      end
   end
   assign rst_n = rst_s_q[1];

   // the level input is quasi static, so a per-bit sync is enough
   always_ff @(posedge link.link_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_q <= 1'b0;
         pin_s2_q <= 1'b0;
         fn_s1_q  <= 8'h00;
         fn_s2_q  <= 8'h00;
      end else begin
         pin_s1_q <= link.enable_pwm_input;
         pin_s2_q <= pin_s1_q;
         fn_s1_q  <= pwm_filter_node;
         fn_s2_q  <= fn_s1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // enable detection
   ldp_wake_e        st_q;
   ldp_wake_e        st_d;
   logic [CNT_W-1:0] tcnt_q;
   logic [CNT_W-1:0] tcnt_d;
   logic             wake_done;
   logic             off_done;

   assign wake_done = (tcnt_q >= CNT_W'(WAKE_CYC - 1));
   assign off_done  = (tcnt_q >= CNT_W'(OFF_CYC));

   always_comb begin
      st_d   = st_q;
      tcnt_d = '0;
      unique case (st_q)
         ST_SLEEP: begin
            if (pin_s2_q) begin
               st_d = ST_QUAL;
            end
         end
         ST_QUAL: begin
            if (!pin_s2_q) begin
               st_d = ST_SLEEP;
            end else if (wake_done) begin
               st_d = ST_AWAKE; // RULE1
            end else begin
               tcnt_d = tcnt_q + CNT_W'(1);
            end
         end
         ST_AWAKE: begin
            if (pin_s2_q) begin
               tcnt_d = '0;
            end else if (off_done) begin
               st_d = ST_SLEEP; // RULE2
            end else begin
               tcnt_d = tcnt_q + CNT_W'(1);
            end
         end
         default: begin
            st_d = ST_SLEEP;
         end
      endcase
   end

   always_ff @(posedge link.link_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q   <= ST_SLEEP;
         tcnt_q <= '0;
      end else begin
         st_q   <= st_d;
         tcnt_q <= tcnt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers
   logic [7:0]       lvl_q;
   logic [7:0]       mode_q;
   logic [7:0]       dcl_q;
   logic [7:0]       rdata_q;
   logic             rack_q;
   logic             hit_lvl;
   logic             hit_mode;
   logic             hit_dcl;
   logic [7:0]       rd_mux;

   assign hit_lvl  = (link.reg_addr == ADDR_LVL);
   assign hit_mode = (link.reg_addr == ADDR_MODE);
   assign hit_dcl  = (link.reg_addr == ADDR_DCL);
   assign rd_mux   = hit_lvl  ? lvl_q  :
                     hit_mode ? mode_q :
                     hit_dcl  ? dcl_q  : 8'h00;

   // a request is held a full link period, so it is taken on its one rising edge
   always_ff @(posedge link.link_clk or negedge rst_n) begin
      if (!rst_n) begin
         lvl_q   <= LVL_RST;  // RULE9
         mode_q  <= MODE_RST; // RULE7
         dcl_q   <= DCL_RST;  // RULE3
         rdata_q <= 8'h00;
         rack_q  <= 1'b0;
      end else begin
         if (link.reg_wr && hit_lvl) begin
            lvl_q <= link.reg_wdata; // RULE9
         end
         if (link.reg_wr && hit_mode) begin
            mode_q <= link.reg_wdata; // RULE11 RULE12 RULE14
         end
         if (link.reg_wr && hit_dcl) begin
            dcl_q <= link.reg_wdata; // RULE3 RULE4
         end
         if (link.reg_rd) begin
            rdata_q <= rd_mux;
            rack_q  <= ~rack_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // internal oscillator, external duty filter and duty selection
   logic [15:0]      pre_q;
   logic [7:0]       cnt_q;
   logic [15:0]      avg_q;
   logic [15:0]      avg_d;
   logic             tick;
   logic [7:0]       fn_c;
   logic [7:0]       fn_fac;
   logic [7:0]       ext_duty;
   logic [7:0]       eff;
   logic             is_ext;
   logic             gate_on;

   assign tick = (pre_q == 16'(PWM_DIV - 1));
   // first order filter stands in for the averaging network on the input
   assign avg_d = pin_s2_q ? avg_q + ((16'hFF00 - avg_q) >> EXT_FILT_SH)
                           : avg_q - (avg_q >> EXT_FILT_SH);
   assign ext_duty = avg_q[15:8];
   assign fn_c   = (fn_s2_q < FN_LO) ? FN_LO : (fn_s2_q > FN_HI) ? FN_HI : fn_s2_q;
   assign fn_fac = 8'((16'(FN_HI - fn_c) * 16'h00FF) / 16'(FN_SPAN)); // RULE16
   assign is_ext = (mode_q == MODE_EXT);
   assign eff    = (mode_q == MODE_INT) ? lvl_q :                 // RULE8
                   (mode_q == MODE_DC)  ? ldp_frac(lvl_q, fn_fac) : // RULE16
                   ldp_frac(lvl_q, ext_duty);                      // RULE15
   // external mode passes the input straight through, keeping its frequency
   assign gate_on = (st_q == ST_AWAKE) && (lvl_q != 8'h00) && (dcl_q != 8'h00) && // RULE5 RULE10
                    (is_ext ? pin_s2_q : (cnt_q < eff)); // RULE17 RULE18

   always_ff @(posedge link.link_clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_q <= 16'h0000;
         cnt_q <= 8'h00;
         avg_q <= 16'h0000;
      end else begin
         pre_q <= tick ? 16'h0000 : pre_q + 16'h0001;
         if (tick) begin
            cnt_q <= (cnt_q == PWM_LAST) ? 8'h00 : cnt_q + 8'h01; // RULE18
         end
         avg_q <= avg_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // channel outputs
   genvar ch;
   generate
      for (ch = 0; ch < 6; ch++) begin : g_ch
         always_ff @(posedge link.link_clk or negedge rst_n) begin
            if (!rst_n) begin
               led_gate[ch] <= 1'b0;
            end else begin
               led_gate[ch] <= gate_on; // RULE6
            end
         end
      end
   endgenerate

   logic awake_q;
   always_ff @(posedge link.link_clk or negedge rst_n) begin
      if (!rst_n) begin
         dc_level <= 8'h00;
         awake_q  <= 1'b0;
      end else begin
         dc_level <= (st_q == ST_AWAKE) ? dcl_q : 8'h00; // RULE4
         awake_q  <= (st_q == ST_AWAKE);
      end
   end

   assign link.reg_rdata = rdata_q;
   assign link.reg_rack  = rack_q;
   assign link.awake     = awake_q;
endmodule : ldp_device

// file: ldp_host.sv
// ldp_host: apb controlled host that drives the link and an external pwm
// assumes pclk at 100 MHz; the link clock is pclk divided by four
`timescale 1ns/100ps
module ldp_host (
   // apb slave
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // link to the device
   ldp_link_if.host         link
);
   import ldp_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // link clock divider; requests change only at the falling edge
   logic [1:0]  div_q;
   logic        lclk_q;
   logic        launch;

   assign launch = (div_q == 2'(LINK_DIV - 1));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q  <= 2'b00;
         lclk_q <= 1'b0;
      end else begin
         div_q  <= div_q + 2'b01;
         lclk_q <= (div_q == 2'b01) || (div_q == 2'b10);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // returns from the device
   logic        ack_s1_q;
   logic        ack_s2_q;
   logic        ack_s3_q;
   logic        awk_s1_q;
   logic        awk_s2_q;
   logic        ack_evt;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_s1_q <= 1'b0;
         ack_s2_q <= 1'b0;
         ack_s3_q <= 1'b0;
         awk_s1_q <= 1'b0;
         awk_s2_q <= 1'b0;
      end else begin
         ack_s1_q <= link.reg_rack;
         ack_s2_q <= ack_s1_q;
         ack_s3_q <= ack_s2_q;
         awk_s1_q <= link.awake;
         awk_s2_q <= awk_s1_q;
      end
   end
   assign ack_evt = ack_s2_q ^ ack_s3_q;

   ////////////////////////////////////////////////////////////////////////////
   // apb registers
   logic [7:0]  daddr_q;
   logic [7:0]  ddata_q;
   logic [7:0]  rdat_q;
   logic [15:0] per_q;
   logic [15:0] high_q;
   logic        wr_q;
   logic        rd_q;
   logic        pend_q;
   logic        busy_q;
   logic        setup;
   logic        acc_wr;
   logic        mapped;
   logic        cmd_go;
   logic [31:0] rd_mux;

   assign setup  = psel && !penable;
   assign acc_wr = psel && penable && pready && pwrite;
   assign mapped = (paddr == H_DEV_ADDR) || (paddr == H_DEV_DATA) || (paddr == H_CMD) ||
                   (paddr == H_RDATA) || (paddr == H_PWM_PER) || (paddr == H_PWM_HIGH) ||
                   (paddr == H_STATUS);
   // commands that arrive while one is in flight are dropped
   assign cmd_go = acc_wr && (paddr == H_CMD) && !busy_q;
   assign rd_mux = (paddr == H_DEV_ADDR) ? {24'h000000, daddr_q} :
                   (paddr == H_DEV_DATA) ? {24'h000000, ddata_q} :
                   (paddr == H_CMD)      ? {31'h00000000, busy_q} :
                   (paddr == H_RDATA)    ? {24'h000000, rdat_q} :
                   (paddr == H_PWM_PER)  ? {16'h0000, per_q} :
                   (paddr == H_PWM_HIGH) ? {16'h0000, high_q} :
                   (paddr == H_STATUS)   ? {31'h00000000, awk_s2_q} : 32'h00000000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
         daddr_q <= 8'h00;
         ddata_q <= 8'h00;
         per_q   <= PWM_PER_RST;
         high_q  <= PWM_HIGH_RST;
      end else begin
         pready  <= setup;
         pslverr <= setup && !mapped;
         prdata  <= setup ? rd_mux : 32'h00000000;
         if (acc_wr && (paddr == H_DEV_ADDR)) begin
            daddr_q <= pwdata[7:0];
         end
         if (acc_wr && (paddr == H_DEV_DATA)) begin
            ddata_q <= pwdata[7:0];
         end
         if (acc_wr && (paddr == H_PWM_PER)) begin
            per_q <= pwdata[15:0];
         end
         if (acc_wr && (paddr == H_PWM_HIGH)) begin
            high_q <= pwdata[15:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // command sequencing: a request stands one full link period
   logic        lwr_q;
   logic        lrd_q;
   logic        waitrd_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_q     <= 1'b0;
         rd_q     <= 1'b0;
         pend_q   <= 1'b0;
         busy_q   <= 1'b0;
         lwr_q    <= 1'b0;
         lrd_q    <= 1'b0;
         waitrd_q <= 1'b0;
         rdat_q   <= 8'h00;
      end else begin
         if (cmd_go) begin
            wr_q   <= pwdata[CMD_WR_BIT];
            rd_q   <= pwdata[CMD_RD_BIT] && !pwdata[CMD_WR_BIT];
            pend_q <= pwdata[CMD_WR_BIT] || pwdata[CMD_RD_BIT];
            busy_q <= pwdata[CMD_WR_BIT] || pwdata[CMD_RD_BIT];
         end else if (launch) begin
            if (pend_q) begin
               lwr_q  <= wr_q;
               lrd_q  <= rd_q;
               pend_q <= 1'b0;
            end else begin
               lwr_q <= 1'b0;
               lrd_q <= 1'b0;
               if (lwr_q) begin
                  busy_q <= 1'b0;
               end
               if (lrd_q) begin
                  waitrd_q <= 1'b1;
               end
            end
         end
         if (waitrd_q && ack_evt) begin
            rdat_q   <= link.reg_rdata;
            waitrd_q <= 1'b0;
            busy_q   <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // external pwm source
   logic [15:0] pcnt_q;
   logic        pin_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pcnt_q <= 16'h0000;
         pin_q  <= 1'b0;
      end else begin
         pcnt_q <= (pcnt_q >= per_q - 16'h0001) ? 16'h0000 : pcnt_q + 16'h0001;
         pin_q  <= (pcnt_q < high_q);
      end
   end

   assign link.link_clk         = lclk_q;
   assign link.enable_pwm_input = pin_q;
   assign link.reg_wr           = lwr_q;
   assign link.reg_rd           = lrd_q;
   assign link.reg_addr         = daddr_q;
   assign link.reg_wdata        = ddata_q;
endmodule : ldp_host

// file: ldp_chk.sv
// ldp_chk: link-side assertions of the dimming device
// assumes link_clk runs from the host and presetn is the shared reset
`timescale 1ns/100ps
module ldp_chk #(
   parameter int OFF_CYC = 3000
) (
   // link side
   input  wire logic       link_clk,
   input  wire logic       presetn,
   input  wire logic       enable_pwm_input,
   input  wire logic       reg_rd,
   input  wire logic       reg_rack,
   input  wire logic       awake,
   // led drive
   input  wire logic [5:0] led_gate,
   input  wire logic [7:0] dc_level
);
   import ldp_pkg::*;
   default clocking cb @(posedge link_clk); endclocking
   default disable iff (!presetn);

   logic [19:0] hi_q;
   logic [19:0] hi_d;
   logic [19:0] lo_q;
   logic [19:0] lo_d;

   ////////////////////////////////////////////////////////////////////////////////
   // raw pin run lengths; the device sees the pin a few flops later, hence margins
   assign hi_d = !enable_pwm_input ? 20'h00000 : (&hi_q ? hi_q : hi_q + 20'h00001);
   assign lo_d = enable_pwm_input ? 20'h00000 : (&lo_q ? lo_q : lo_q + 20'h00001);

   always_ff @(posedge link_clk or negedge presetn) begin
      if (!presetn) begin
         hi_q <= 20'h00000;
         lo_q <= 20'h00000;
      end else begin
         hi_q <= hi_d;
         lo_q <= lo_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   a_gate_all_same: assert property (led_gate == 6'h00 || led_gate == 6'h3F)
      else $error("led channels gated apart");
   a_wake_not_early: assert property ($rose(awake) |-> hi_q >= WAKE_CYC)
      else $error("woke on a short pulse");
   a_wake_in_time: assert property (hi_q == WAKE_CYC + 12 |-> awake)
      else $error("long pulse did not wake");
   a_sleep_not_early: assert property ($fell(awake) |-> lo_q > OFF_CYC)
      else $error("shutdown before off limit");
   a_sleep_in_time: assert property (lo_q == OFF_CYC + 12 |-> !awake)
      else $error("no shutdown after off limit");
   a_dark_asleep: assert property (!awake ##1 !awake |-> led_gate == 6'h00 && dc_level == 8'h00)
      else $error("drive active while asleep");
   a_dc_zero_dark: assert property (dc_level == 8'h00 ##1 dc_level == 8'h00 |-> led_gate == 6'h00)
      else $error("gate on with zero dc level");
   a_rack_on_read: assert property (reg_rd |=> reg_rack != $past(reg_rack))
      else $error("read not acknowledged");
   a_rack_needs_read: assert property (reg_rack != $past(reg_rack) |-> $past(reg_rd))
      else $error("acknowledge without read");

   c_wake: cover property ($rose(awake));
   c_sleep: cover property ($fell(awake));
   c_gate_on: cover property ($rose(led_gate[0]));
   c_read: cover property (reg_rd ##1 reg_rack != $past(reg_rack));
endmodule : ldp_chk

// file: ldp_bench.sv
// ldp_bench: host and device joined by the link, driven over apb
// assumes pclk 100 MHz; shutdown count shortened to OFF_SIM link cycles
`timescale 1ns/100ps
module ldp_bench;
   import ldp_pkg::*;
   localparam int OFF_SIM = 3000;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [7:0]  node;
   logic [5:0]  led_gate;
   logic [7:0]  dc_level;
   logic [31:0] rdv;
   logic        ev;
   int          err_count;
   int          n_compared;
   int          hi;

   ldp_link_if lnk();
   ldp_host i_ldp_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(lnk));
   ldp_device #(.OFF_CYC(OFF_SIM), .PWM_DIV(1)) i_ldp_device (.link(lnk), .presetn(presetn),
      .pwm_filter_node(node), .led_gate(led_gate), .dc_level(dc_level));
   ldp_chk #(.OFF_CYC(OFF_SIM)) i_ldp_chk (.link_clk(lnk.link_clk), .presetn(presetn),
      .enable_pwm_input(lnk.enable_pwm_input), .reg_rd(lnk.reg_rd), .reg_rack(lnk.reg_rack),
      .awake(lnk.awake), .led_gate(led_gate), .dc_level(dc_level));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // duty counts jitter with the pin sync, so they get a tolerance
   task chk_near(input int got, input int exp, input int tol);
      n_compared++;
      if (got < exp - tol || got > exp + tol) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_near

   task tally_and_finish;
      $display("compared=%0d mismatches=%0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish

   task waitc(input int n);
      repeat (n) @(posedge pclk);
   endtask : waitc

   task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      // no cycle count is assumed; only the watchdog ends a stuck wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // one device register transfer; busy is polled, never assumed
   task dev(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [31:0] rd);
      apb(1'b1, H_DEV_ADDR, {24'h000000, a}, rd, ev);
      apb(1'b1, H_DEV_DATA, {24'h000000, d}, rd, ev);
      apb(1'b1, H_CMD, wr ? 32'h00000001 : 32'h00000002, rd, ev);
      do begin
         apb(1'b0, H_CMD, 32'h0, rd, ev);
      end while (rd[0] !== 1'b0);
      apb(1'b0, H_RDATA, 32'h0, rd, ev);
   endtask : dev

   task set_ext(input logic [15:0] per, input logic [15:0] high);
      apb(1'b1, H_PWM_PER, {16'h0000, per}, rdv, ev);
      apb(1'b1, H_PWM_HIGH, {16'h0000, high}, rdv, ev);
   endtask : set_ext

   task status(input logic exp);
      apb(1'b0, H_STATUS, 32'h0, rdv, ev);
      chk(rdv, {31'h0, exp});
   endtask : status

   // counts link cycles with all six channels on
   task meas(input int n, output int h);
      h = 0;
      repeat (n) begin
         @(posedge lnk.link_clk);
         if (led_gate === 6'h3F) h++;
      end
   endtask : meas

   ////////////////////////////////////////////////////////////////////////////////
   task t_regs;
      logic [7:0] modes [4];
      modes = '{MODE_INT, MODE_EXT, MODE_DC, MODE_RATIO};
      dev(1'b0, ADDR_LVL, 8'h00, rdv);
      chk(rdv, {24'h0, LVL_RST});
      dev(1'b0, ADDR_MODE, 8'h00, rdv);
      chk(rdv, {24'h0, MODE_RATIO});
      dev(1'b0, ADDR_DCL, 8'h00, rdv);
      chk(rdv, {24'h0, DCL_RST});
      dev(1'b1, ADDR_DCL, 8'h5A, rdv);
      dev(1'b0, ADDR_DCL, 8'h00, rdv);
      chk(rdv, 32'h0000005A);
      dev(1'b1, ADDR_DCL, DCL_RST, rdv);
      dev(1'b0, 8'h05, 8'h00, rdv);
      chk(rdv, 32'h0);
      apb(1'b0, 8'h40, 32'h0, rdv, ev);
      chk({31'h0, ev}, 32'h1);
      foreach (modes[i]) begin
         dev(1'b1, ADDR_MODE, modes[i], rdv);
         dev(1'b0, ADDR_MODE, 8'h00, rdv);
         chk(rdv, {24'h0, modes[i]});
      end
      $display("test regs done");
   endtask : t_regs

   task t_wake;
      set_ext(16'h1000, 16'h0000);
      waitc(100);
      set_ext(16'h1000, 16'h1000);
      waitc(3000);
      status(1'b0);
      waitc(2000);
      status(1'b1);
      $display("test wake done");
   endtask : t_wake

   task t_internal;
      logic [7:0] b [4];
      b = '{8'h00, 8'h01, 8'h80, 8'hFF};
      dev(1'b1, ADDR_MODE, MODE_INT, rdv);
      foreach (b[i]) begin
         dev(1'b1, ADDR_LVL, b[i], rdv);
         waitc(80);
         meas(255, hi);
         chk_near(hi, int'(b[i]), 0);
      end
      dev(1'b1, ADDR_DCL, 8'hC8, rdv);
      waitc(20);
      chk({24'h0, dc_level}, 32'h000000C8);
      meas(255, hi);
      chk_near(hi, 255, 0);
      dev(1'b1, ADDR_DCL, 8'h00, rdv);
      waitc(20);
      chk({24'h0, dc_level}, 32'h0);
      meas(255, hi);
      chk_near(hi, 0, 0);
      dev(1'b1, ADDR_DCL, DCL_RST, rdv);
      $display("test internal done");
   endtask : t_internal

   // pin at 30 percent, 25 link cycles a period
   task t_ext_ratio;
      set_ext(16'h0064, 16'h001E);
      dev(1'b1, ADDR_MODE, MODE_EXT, rdv);
      waitc(40);
      meas(500, hi);
      chk_near(hi, 150, 10);
      dev(1'b1, ADDR_MODE, MODE_RATIO, rdv);
      waitc(2000);
      meas(510, hi);
      chk_near(hi, 153, 25);
      dev(1'b1, ADDR_LVL, 8'h80, rdv);
      waitc(200);
      meas(510, hi);
      chk_near(hi, 77, 20);
      $display("test ext_ratio done");
   endtask : t_ext_ratio

   task t_dcpwm;
      logic [7:0] v [4];
      int         e [4];
      v = '{8'h15, 8'h1F, 8'h79, 8'h0A};
      e = '{255, 229, 0, 255};
      dev(1'b1, ADDR_LVL, 8'hFF, rdv);
      dev(1'b1, ADDR_MODE, MODE_DC, rdv);
      foreach (v[i]) begin
         @(posedge pclk);
         node <= v[i];
         waitc(80);
         meas(255, hi);
         chk_near(hi, e[i], 2);
      end
      $display("test dcpwm done");
   endtask : t_dcpwm

   task t_off;
      set_ext(16'h0064, 16'h0000);
      waitc(11000);
      status(1'b1);
      waitc(1600);
      status(1'b0);
      chk({24'h0, dc_level}, 32'h0);
      set_ext(16'h2000, 16'h07D0);
      waitc(20000);
      status(1'b0);
      $display("test off done");
   endtask : t_off

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      err_count = 0;
      n_compared = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      node = 8'h15;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      waitc(20);
      t_regs();
      t_wake();
      t_internal();
      t_ext_ratio();
      t_dcpwm();
      t_off();
      tally_and_finish();
   end

   // whole run needs about 60k cycles
   initial begin
      repeat (90000) @(posedge pclk);
      err_count++;
      $display("[ERR] t=%0t watchdog expired", $time);
      tally_and_finish();
   end
endmodule : ldp_bench
